// ### rtl/mms_pkg.sv
// constants shared by the magnetometer serial slave port
// assumes a single 100 MHz system clock domain
package mms_pkg;
	// ----------------------------------------------------------------
	// widths and counts
	// ----------------------------------------------------------------
	localparam int CMD_W = 8;
	localparam int RES_W = 16;
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [4:0] RES_BITS = 5'h10;
	localparam logic [4:0] CNT_RESET = 5'h00;
	// ----------------------------------------------------------------
	// command byte layout
	// ----------------------------------------------------------------
	localparam int AXIS_LSB = 0;
	localparam int AXIS_MSB = 1;
	localparam int OSC_TEST_BIT = 2;
	localparam int OSC_DIR_BIT = 3;
	localparam int RATIO_LSB = 4;
	localparam int RATIO_MSB = 6;
	localparam int DIAG_CLK_BIT = 7;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [15:0] RES_RESET = 16'h0000;
	localparam logic [1:0] AXIS_X = 2'h1;
	localparam logic [1:0] AXIS_Y = 2'h2;
	localparam logic [2:0] RATIO_DIV32 = 3'h0;
	localparam logic [2:0] RATIO_DIV2048 = 3'h6;
	localparam logic [2:0] RATIO_DIV4096 = 3'h7;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_MEAS,
		ST_OUT
	} mms_state_e;
endpackage

// ### rtl/mms_buf2.sv
// two-entry valid/ready buffer
// assumes both sides run on the same clock
module mms_buf2 import mms_pkg::*; #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [WIDTH-1:0] spare_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != 2'h2);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_next = cnt_reg - 2'h1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
			out_valid <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			out_valid <= (cnt_next != 2'h0);
		end
	end

	// head word sits in out_data so the output is a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= '0;
			spare_reg <= '0;
		end else if (pop) begin
			if (cnt_reg == 2'h2)
				out_data <= spare_reg;
			else if (push)
				out_data <= in_data;
		end else if (push) begin
			if (cnt_reg == 2'h0)
				out_data <= in_data;
			else
				spare_reg <= in_data;
		end
	end
endmodule

// ### rtl/mms_spi_slave.sv
// serial slave port of a two-axis magnetometer
// assumes pins are asynchronous to REF_CLK and SCLK is far slower
module mms_spi_slave import mms_pkg::*; (
	// system
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// serial pins
	input wire logic SCLK,
	input wire logic MOSI,
	input wire logic SLAVE_SELECT_N,
	input wire logic MEAS_RESET,
	output logic MISO,
	output logic MISO_OE,
	output logic RESULT_READY,
	// command stream to the measurement engine
	output logic CMD_VALID,
	output logic [CMD_W-1:0] CMD_DATA,
	input wire logic CMD_READY,
	// decoded command fields
	output logic [1:0] AXIS_SELECT,
	output logic [2:0] RATIO_SELECT,
	output logic OSC_TEST_ENABLE,
	output logic OSC_TEST_DIRECTION,
	output logic DIAG_CLOCK_OUTPUT_ENABLE,
	output logic OVERFLOW_POSSIBLE,
	// result from the measurement engine
	input wire logic RES_VALID,
	input wire logic [RES_W-1:0] RES_DATA,
	output logic RES_READY
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 4;
	localparam logic [NPIN-1:0] PIN_RESET = 4'h2;
	logic [NPIN-1:0] pin_in;
	logic [NPIN-1:0] meta_reg;
	logic [NPIN-1:0] sync_reg;
	logic sclk_s, mosi_s, ssn_s, rst_s;
	logic sclk_d_reg;
	logic sclk_rise, sclk_fall;

	assign pin_in = {SCLK, MOSI, SLAVE_SELECT_N, MEAS_RESET};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge REF_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					meta_reg[gi] <= PIN_RESET[gi];
					sync_reg[gi] <= PIN_RESET[gi];
				end else begin
					meta_reg[gi] <= pin_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	assign {sclk_s, mosi_s, ssn_s, rst_s} = sync_reg;

	// serial clock is only ever observed, never driven
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			sclk_d_reg <= 1'b0;
		else
			sclk_d_reg <= sclk_s;
	end

	assign sclk_rise = sclk_s & ~sclk_d_reg & ~ssn_s;
	assign sclk_fall = ~sclk_s & sclk_d_reg & ~ssn_s;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	mms_state_e state_reg;
	logic [4:0] bit_cnt_reg;
	logic [CMD_W-1:0] shift_in_reg;
	logic [CMD_W-1:0] cmd_next;
	logic [RES_W-1:0] result_reg;
	logic [RES_W-1:0] shift_out_reg;
	logic cmd_done, buf_in_ready, res_take;

	assign cmd_next = {shift_in_reg[CMD_W-2:0], mosi_s};
	assign cmd_done = (state_reg == ST_CMD) && sclk_rise && !rst_s &&
		(bit_cnt_reg == CMD_LAST_BIT);
	assign res_take = RES_VALID & RES_READY;

	// a held reset pin parks the port ready for a fresh command
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= ST_IDLE;
		end else if (rst_s) begin
			state_reg <= ST_CMD;
		end else begin
			case (state_reg)
				ST_IDLE: state_reg <= ST_IDLE;
				ST_CMD: begin
					// a full buffer drops the command
					if (cmd_done)
						state_reg <= buf_in_ready ? ST_MEAS : ST_IDLE;
				end
				ST_MEAS: begin
					// select is not looked at here
					if (res_take)
						state_reg <= ST_OUT;
				end
				ST_OUT: begin
					if (sclk_rise && bit_cnt_reg == RES_BITS - 5'h01)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bit_cnt_reg <= CNT_RESET;
			shift_in_reg <= CMD_RESET;
		end else if (rst_s || res_take) begin
			bit_cnt_reg <= CNT_RESET;
		end else if (sclk_rise) begin
			if (state_reg == ST_CMD) begin
				shift_in_reg <= cmd_next;
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end else if (state_reg == ST_OUT) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			AXIS_SELECT <= CMD_RESET[AXIS_MSB:AXIS_LSB];
			OSC_TEST_ENABLE <= CMD_RESET[OSC_TEST_BIT];
			OSC_TEST_DIRECTION <= CMD_RESET[OSC_DIR_BIT];
			RATIO_SELECT <= CMD_RESET[RATIO_MSB:RATIO_LSB];
			DIAG_CLOCK_OUTPUT_ENABLE <= CMD_RESET[DIAG_CLK_BIT];
			OVERFLOW_POSSIBLE <= 1'b0;
		end else if (cmd_done && buf_in_ready) begin
			AXIS_SELECT <= cmd_next[AXIS_MSB:AXIS_LSB];
			OSC_TEST_ENABLE <= cmd_next[OSC_TEST_BIT];
			OSC_TEST_DIRECTION <= cmd_next[OSC_DIR_BIT];
			RATIO_SELECT <= cmd_next[RATIO_MSB:RATIO_LSB];
			DIAG_CLOCK_OUTPUT_ENABLE <= cmd_next[DIAG_CLK_BIT];
			// only the top ratio can run past a signed 16-bit count
			OVERFLOW_POSSIBLE <=
				(cmd_next[RATIO_MSB:RATIO_LSB] == RATIO_DIV4096);
		end
	end

	mms_buf2 #(.WIDTH(CMD_W)) u_cmd_buf (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.in_valid(cmd_done),
		.in_data(cmd_next),
		.in_ready(buf_in_ready),
		.out_valid(CMD_VALID),
		.out_data(CMD_DATA),
		.out_ready(CMD_READY)
	);

	// ----------------------------------------------------------------
	// result handshake and shift-out
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RES_READY <= 1'b0;
			RESULT_READY <= 1'b0;
			result_reg <= RES_RESET;
		end else if (rst_s) begin
			RES_READY <= 1'b0;
			RESULT_READY <= 1'b0;
		end else begin
			if (cmd_done && buf_in_ready)
				RES_READY <= 1'b1;
			else if (res_take)
				RES_READY <= 1'b0;
			if (res_take) begin
				result_reg <= RES_DATA;
				RESULT_READY <= 1'b1;
			end
		end
	end

	// first bit is set up before the master's first rising edge
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MISO <= 1'b0;
			shift_out_reg <= RES_RESET;
		end else if (res_take) begin
			MISO <= RES_DATA[RES_W-1];
			shift_out_reg <= {RES_DATA[RES_W-2:0], 1'b0};
		end else if (state_reg == ST_OUT && sclk_fall &&
			bit_cnt_reg != CNT_RESET) begin
			MISO <= shift_out_reg[RES_W-1];
			shift_out_reg <= {shift_out_reg[RES_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			MISO_OE <= 1'b0;
		else
			MISO_OE <= ~ssn_s;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_oe_when_deselected: assert property (
		ssn_s |=> !MISO_OE) else $error("output driven while deselected");
	a_ready_cleared: assert property (
		rst_s |=> !RESULT_READY) else $error("ready not cleared by reset");
	a_ready_on_result: assert property (
		res_take |=> RESULT_READY && result_reg == $past(RES_DATA))
		else $error("ready or result missing after take");
	a_idle_ignores_clock: assert property (
		state_reg == ST_IDLE && !rst_s |=> $stable(bit_cnt_reg))
		else $error("bits counted without reset pulse");
	a_select_gates_data: assert property (
		state_reg == ST_CMD && ssn_s && !rst_s |=> $stable(shift_in_reg))
		else $error("data taken while deselected");
	a_fields_from_cmd: assert property (
		cmd_done && buf_in_ready |=> {DIAG_CLOCK_OUTPUT_ENABLE, RATIO_SELECT,
		OSC_TEST_DIRECTION, OSC_TEST_ENABLE, AXIS_SELECT} == $past(cmd_next))
		else $error("command fields wrong");
	a_eight_bit_cmd: assert property (
		(state_reg == ST_CMD && !rst_s) ##1 (state_reg == ST_MEAS)
		|-> $past(bit_cnt_reg) == CMD_LAST_BIT)
		else $error("command left before eighth bit");
	a_meas_persists: assert property (
		state_reg == ST_MEAS && !rst_s && !res_take |=> state_reg == ST_MEAS)
		else $error("measurement abandoned");
	a_msb_first_out: assert property (
		res_take |=> MISO == result_reg[RES_W-1])
		else $error("first output bit not msb");
	a_out_on_fall: assert property (
		state_reg == ST_OUT && !sclk_fall |=> $stable(MISO))
		else $error("output changed off a falling edge");
endmodule

// ### test/mms_host_model.sv
// serial master model facing the magnetometer port
// assumes clk is the 100 MHz system clock; pins move on its falling edge
module mms_host_model (
	// clock
	input wire logic clk,
	// pins
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic ss_n,
	output logic meas_rst
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// link timing
	// ----------------------------------------------------------------
	// 80 ns half period, a 6.25 MHz serial clock, above the 1 MHz ceiling
	localparam int HALF = 8;
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
		meas_rst = 1'b0;
	end
	task automatic half_period();
		repeat (HALF) @(negedge clk);
	endtask
	task automatic select(input logic en);
		@(negedge clk);
		ss_n = ~en;
		half_period();
	endtask
	task automatic pulse_reset();
		@(negedge clk);
		meas_rst = 1'b1;
		repeat (4) @(negedge clk);
		meas_rst = 1'b0;
		half_period();
	endtask
	// ----------------------------------------------------------------
	// one byte each way
	// ----------------------------------------------------------------
	task automatic xfer8(input logic [7:0] dout, output logic [7:0] din);
		din = 8'h00;
		@(negedge clk);
		for (int i = 7; i >= 0; i--) begin
			mosi = dout[i];
			half_period();
			sclk = 1'b1;
			din = {din[6:0], miso};
			half_period();
			sclk = 1'b0;
		end
		// stale level never passes for a live bit
		mosi = ~mosi;
	endtask
endmodule

// ### test/mms_spi_slave_tb.sv
// self-checking bench for the magnetometer serial slave port
// assumes the host model drives the pins; this bench plays the engine
module mms_spi_slave_tb import mms_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic reset_n;
	logic sclk, mosi, ss_n, meas_rst, miso, miso_oe, result_ready;
	logic cmd_valid, res_ready, ovf, ote, otd, dce;
	logic cmd_ready;
	logic res_valid;
	logic [7:0] cmd_data, c, hi, lo;
	logic [1:0] axis;
	logic [2:0] ratio;
	logic [15:0] res_data;
	wire miso_wire;
	int fails = 0;
	int cmp_count = 0;
	// command byte beside the result handed back
	logic [23:0] rows [8] = '{24'h018000, 24'h127FFF, 24'h250001,
		24'h3AFFFF, 24'h41A5A5, 24'hD25A5A, 24'h6D1234, 24'hF28001};
	assign miso_wire = miso_oe ? miso : 1'bz;
	always #5 ref_clk = ~ref_clk;
	mms_host_model host (.clk(ref_clk), .miso(miso_wire), .sclk(sclk),
		.mosi(mosi), .ss_n(ss_n), .meas_rst(meas_rst));
	mms_spi_slave uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .SCLK(sclk),
		.MOSI(mosi), .SLAVE_SELECT_N(ss_n), .MEAS_RESET(meas_rst),
		.MISO(miso), .MISO_OE(miso_oe), .RESULT_READY(result_ready),
		.CMD_VALID(cmd_valid), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
		.AXIS_SELECT(axis), .RATIO_SELECT(ratio), .OSC_TEST_ENABLE(ote),
		.OSC_TEST_DIRECTION(otd), .DIAG_CLOCK_OUTPUT_ENABLE(dce),
		.OVERFLOW_POSSIBLE(ovf), .RES_VALID(res_valid),
		.RES_DATA(res_data), .RES_READY(res_ready));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic fields(input logic [7:0] b);
		check("fields", {8'h00, dce, ratio, otd, ote, axis}, {8'h00, b});
		check("ovf", {15'h0000, ovf}, {15'h0000, b[6:4] == RATIO_DIV4096});
	endtask
	task automatic pop(input logic [7:0] exp);
		check("cmd_valid", {15'h0000, cmd_valid}, 16'h0001);
		check("cmd_data", {8'h00, cmd_data}, {8'h00, exp});
		cmd_ready = 1'b1;
		@(negedge ref_clk);
		cmd_ready = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic give_result(input logic [15:0] r);
		int k;
		res_data = r;
		res_valid = 1'b1;
		for (k = 0; k < 64 && res_ready !== 1'b1; k++)
			@(negedge ref_clk);
		if (k == 64) begin
			check("res_ready", 16'h0000, 16'h0001);
			finish_test();
		end
		@(negedge ref_clk);
		res_valid = 1'b0;
		res_data = ~r;
		check("ready_res", {15'h0000, result_ready}, 16'h0001);
		check("res_ready_low", {15'h0000, res_ready}, 16'h0000);
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		cmd_ready = 1'b0;
		res_valid = 1'b0;
		res_data = 16'h0000;
		repeat (16) @(negedge ref_clk);
		reset_n = 1'b1;
		@(negedge ref_clk);
		check("ready_rst", {15'h0000, result_ready}, 16'h0000);
		check("oe_rst", {15'h0000, miso_oe}, 16'h0000);
		fields(8'h00);
		host.select(1'b1);
		check("oe_sel", {15'h0000, miso_oe}, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			c = rows[i][23:16];
			host.pulse_reset();
			host.xfer8(c, hi);
			repeat (4) @(negedge ref_clk);
			fields(c);
			check("ready_meas", {15'h0000, result_ready}, 16'h0000);
			pop(c);
			give_result(rows[i][15:0]);
			host.xfer8(8'h00, hi);
			host.xfer8(8'h00, lo);
			check("result", {hi, lo}, rows[i][15:0]);
		end
		// bits sent while deselected must not count
		host.pulse_reset();
		host.select(1'b0);
		host.xfer8(8'h8E, hi);
		host.select(1'b1);
		host.xfer8(8'h16, hi);
		host.select(1'b0);
		fields(8'h16);
		pop(8'h16);
		check("cmd_empty", {15'h0000, cmd_valid}, 16'h0000);
		give_result(16'hC3C3);
		check("oe_desel", {15'h0000, miso_oe}, 16'h0000);
		host.select(1'b1);
		host.xfer8(8'h00, hi);
		host.select(1'b0);
		host.select(1'b1);
		host.xfer8(8'h00, lo);
		check("res_split", {hi, lo}, 16'hC3C3);
		// engine stalls: third command finds the buffer full
		host.pulse_reset();
		host.xfer8(8'h01, hi);
		host.pulse_reset();
		host.xfer8(8'h62, hi);
		host.pulse_reset();
		host.xfer8(8'h72, hi);
		repeat (4) @(negedge ref_clk);
		fields(8'h62);
		pop(8'h01);
		pop(8'h62);
		check("cmd_drained", {15'h0000, cmd_valid}, 16'h0000);
		finish_test();
	end
endmodule
